// File: verilog/lsirq_regs.sv
`timescale 1ns/1ps
`include "lsirq_cfg.svh"

module lsirq_regs #(
    parameter logic [3:0] DIE_REVISION = 4'h1,  // arbitrary value
    parameter logic [5:0] PART_ID      = 6'h2a, // arbitrary value
    parameter logic [1:0] VARIANT_CODE = 2'h1,  // arbitrary value
    parameter int         STEP_CYCLES  = `LSIRQ_WAIT_STEP_CYC
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    output logic [7:0]       reg_rdata,
    input  wire logic        light_interrupt_enable,
    input  wire logic        conversion_enable,
    input  wire logic        conversion_done,
    input  wire logic [15:0] clear_channel_result,
    input  wire logic        saturation_flag,
    input  wire logic        wait_start,
    input  wire logic [7:0]  wait_count,
    output logic             wait_busy,
    output logic             wait_done,
    output logic [1:0]       conversion_gain_select,
    output logic             long_wait_select,
    output logic             threshold_interrupt_flag,
    output logic             saturation_irq_pending,
    output logic             int_out,
    output logic             int_oe
);
    if (STEP_CYCLES < 1) begin : g_bad_step
        $error("STEP_CYCLES must be at least 1");
    end

    // persistence code to required count
    function automatic logic [5:0] persist_need(input logic [3:0] code);
        if (code <= 4'h3) begin
            persist_need = {2'b00, code};
        end else begin
            persist_need = 6'((code - 4'h3) * `LSIRQ_PERSIST_STEP);
        end
    endfunction

    function automatic logic is_clear_cmd(input logic [7:0] addr);
        is_clear_cmd = (addr == `LSIRQ_ADDR_CLR_CLEAR) || (addr == `LSIRQ_ADDR_CLR_ALL);
    endfunction

    logic [1:0]  rst_sync_q;
    logic        rst_sync_n;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_sync_n = rst_sync_q[1];

    logic [7:0]  low_thr_lo_q;
    logic [7:0]  low_thr_hi_q;
    logic [7:0]  high_thr_lo_q;
    logic [7:0]  high_thr_hi_q;
    logic [7:0]  persist_q;
    logic [7:0]  config_q;
    logic [7:0]  gain_q;
    logic [7:0]  aux_q;

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            low_thr_lo_q  <= `LSIRQ_RST_THR;
            low_thr_hi_q  <= `LSIRQ_RST_THR;
            high_thr_lo_q <= `LSIRQ_RST_THR;
            high_thr_hi_q <= `LSIRQ_RST_THR;
            persist_q     <= `LSIRQ_RST_PERSIST;
            config_q      <= `LSIRQ_RST_CONFIG;
            gain_q        <= `LSIRQ_RST_GAIN;
            aux_q         <= `LSIRQ_RST_AUX;
        end else if (reg_wr) begin
            if (reg_addr == `LSIRQ_ADDR_LOW_THR_LO) begin
                low_thr_lo_q <= reg_wdata;
            end else if (reg_addr == `LSIRQ_ADDR_LOW_THR_HI) begin
                low_thr_hi_q <= reg_wdata;
            end else if (reg_addr == `LSIRQ_ADDR_HIGH_THR_LO) begin
                high_thr_lo_q <= reg_wdata;
            end else if (reg_addr == `LSIRQ_ADDR_HIGH_THR_HI) begin
                high_thr_hi_q <= reg_wdata;
            end else if (reg_addr == `LSIRQ_ADDR_PERSIST) begin
                persist_q <= reg_wdata & `LSIRQ_PERSIST_MASK;
            end else if (reg_addr == `LSIRQ_ADDR_CONFIG) begin
                // reserved bits held at their mandated levels
                config_q <= (reg_wdata & `LSIRQ_CONFIG_MASK) | `LSIRQ_RST_CONFIG;
            end else if (reg_addr == `LSIRQ_ADDR_GAIN) begin
                gain_q <= reg_wdata & `LSIRQ_GAIN_MASK;
            end else if (reg_addr == `LSIRQ_ADDR_AUX) begin
                aux_q <= reg_wdata & `LSIRQ_AUX_MASK;
            end
        end
    end

    logic [15:0] low_threshold;
    logic [15:0] high_threshold;
    logic [3:0]  persistence_code;
    logic        saturation_interrupt_enable;
    logic        out_of_window;

    assign low_threshold               = {low_thr_hi_q, low_thr_lo_q};
    assign high_threshold              = {high_thr_hi_q, high_thr_lo_q};
    assign persistence_code            = persist_q[3:0];
    assign long_wait_select            = config_q[`LSIRQ_LONG_WAIT_BIT];
    assign saturation_interrupt_enable = aux_q[`LSIRQ_SAT_EN_BIT];
    assign out_of_window = (clear_channel_result < low_threshold)
                        || (clear_channel_result > high_threshold);

    always_comb begin
        case (gain_q[1:0])
            2'b00:   conversion_gain_select = lsirq_pkg::LSIRQ_GAIN_X1;
            2'b01:   conversion_gain_select = lsirq_pkg::LSIRQ_GAIN_X4;
            2'b10:   conversion_gain_select = lsirq_pkg::LSIRQ_GAIN_X16;
            default: conversion_gain_select = lsirq_pkg::LSIRQ_GAIN_X64;
        endcase
    end

    logic       clear_cmd;
    logic [5:0] run_q;
    logic       run_hit;
    logic       thr_event;

    assign clear_cmd = reg_wr && is_clear_cmd(reg_addr);
    // one bit wider so a saturated run does not wrap to zero
    assign run_hit   = out_of_window
                    && (({1'b0, run_q} + 7'h01)
                        >= {1'b0, persist_need(persistence_code)});
    assign thr_event = conversion_done && conversion_enable
                    && ((persistence_code == 4'h0) || run_hit);

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            run_q <= 6'h0;
        end else if (conversion_done && !out_of_window) begin
            run_q <= 6'h0;
        end else if (conversion_done && run_q != 6'h3f) begin
            run_q <= run_q + 6'h1;
        end else if (clear_cmd) begin
            run_q <= 6'h0;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            threshold_interrupt_flag <= 1'b0;
        end else if (thr_event) begin
            threshold_interrupt_flag <= 1'b1;
        end else if (clear_cmd) begin
            threshold_interrupt_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            saturation_irq_pending <= 1'b0;
        end else if (saturation_flag && saturation_interrupt_enable) begin
            saturation_irq_pending <= 1'b1;
        end else if (clear_cmd) begin
            saturation_irq_pending <= 1'b0;
        end
    end

    // open-drain active low pin: drive low while saturation or an enabled threshold interrupt is pending
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            int_oe <= 1'b0;
        end else begin
            int_oe <= (threshold_interrupt_flag && light_interrupt_enable)
                   || saturation_irq_pending;
        end
    end
    assign int_out = 1'b0;

    lsirq_wait_timer #(
        .STEP_CYCLES (STEP_CYCLES)
    ) u_wait (
        .clk              (clk),
        .rst_sync_n       (rst_sync_n),
        .start            (wait_start),
        .wait_count       (wait_count),
        .long_wait_select (long_wait_select),
        .busy             (wait_busy),
        .done             (wait_done)
    );

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            if (reg_addr == `LSIRQ_ADDR_LOW_THR_LO) begin
                reg_rdata <= low_thr_lo_q;
            end else if (reg_addr == `LSIRQ_ADDR_LOW_THR_HI) begin
                reg_rdata <= low_thr_hi_q;
            end else if (reg_addr == `LSIRQ_ADDR_HIGH_THR_LO) begin
                reg_rdata <= high_thr_lo_q;
            end else if (reg_addr == `LSIRQ_ADDR_HIGH_THR_HI) begin
                reg_rdata <= high_thr_hi_q;
            end else if (reg_addr == `LSIRQ_ADDR_PERSIST) begin
                reg_rdata <= persist_q;
            end else if (reg_addr == `LSIRQ_ADDR_CONFIG) begin
                reg_rdata <= config_q;
            end else if (reg_addr == `LSIRQ_ADDR_GAIN) begin
                reg_rdata <= gain_q;
            end else if (reg_addr == `LSIRQ_ADDR_AUX) begin
                reg_rdata <= aux_q;
            end else if (reg_addr == `LSIRQ_ADDR_REVISION) begin
                reg_rdata <= {4'h0, DIE_REVISION};
            end else if (reg_addr == `LSIRQ_ADDR_IDENT) begin
                reg_rdata <= {PART_ID, VARIANT_CODE};
            end else begin
                reg_rdata <= 8'h00;
            end
        end
    end
endmodule // lsirq_regs

// File: verilog/lsirq_cfg.svh
`ifndef LSIRQ_CFG_SVH
`define LSIRQ_CFG_SVH

`define LSIRQ_ADDR_LOW_THR_LO   8'h84
`define LSIRQ_ADDR_LOW_THR_HI   8'h85
`define LSIRQ_ADDR_HIGH_THR_LO  8'h86
`define LSIRQ_ADDR_HIGH_THR_HI  8'h87
`define LSIRQ_ADDR_PERSIST      8'h8c
`define LSIRQ_ADDR_CONFIG       8'h8d
`define LSIRQ_ADDR_GAIN         8'h8f
`define LSIRQ_ADDR_AUX          8'h90
`define LSIRQ_ADDR_REVISION     8'h91
`define LSIRQ_ADDR_IDENT        8'h92
`define LSIRQ_ADDR_CLR_CLEAR    8'he6
`define LSIRQ_ADDR_CLR_ALL      8'he7

`define LSIRQ_RST_THR           8'h00
`define LSIRQ_RST_PERSIST       8'h00
`define LSIRQ_RST_CONFIG        8'h40
`define LSIRQ_RST_GAIN          8'h00
`define LSIRQ_RST_AUX           8'h00

`define LSIRQ_PERSIST_MASK      8'h0f
`define LSIRQ_CONFIG_MASK       8'h42
`define LSIRQ_GAIN_MASK         8'h03
`define LSIRQ_AUX_MASK          8'h20
`define LSIRQ_LONG_WAIT_BIT     1
`define LSIRQ_SAT_EN_BIT        5

`define LSIRQ_LONG_WAIT_FACTOR  12
`define LSIRQ_PERSIST_STEP      5

`define LSIRQ_WAIT_STEP_NS      2780000
`define LSIRQ_CLK_PERIOD_NS     100
`define LSIRQ_WAIT_STEP_CYC     (`LSIRQ_WAIT_STEP_NS / `LSIRQ_CLK_PERIOD_NS)

`endif

// File: verilog/lsirq_pkg.sv
package lsirq_pkg;
    typedef enum logic [1:0] {
        LSIRQ_GAIN_X1,
        LSIRQ_GAIN_X4,
        LSIRQ_GAIN_X16,
        LSIRQ_GAIN_X64
    } lsirq_gain_t;

    typedef enum logic [1:0] {
        LSIRQ_WAIT_IDLE,
        LSIRQ_WAIT_RUN,
        LSIRQ_WAIT_DONE
    } lsirq_wait_state_t;
endpackage

// File: verilog/lsirq_wait_timer.sv
`timescale 1ns/1ps
`include "lsirq_cfg.svh"

// wait period: 256 - wait_count steps of 2.78 ms, times 12 when long wait
module lsirq_wait_timer #(
    parameter int STEP_CYCLES = `LSIRQ_WAIT_STEP_CYC
) (
    input  wire logic       clk,
    input  wire logic       rst_sync_n,
    input  wire logic       start,
    input  wire logic [7:0] wait_count,
    input  wire logic       long_wait_select,
    output logic            busy,
    output logic            done
);
    if (STEP_CYCLES < 1) begin : g_bad_step
        $error("STEP_CYCLES must be at least 1");
    end

    logic [31:0]                     tick_q;
    logic [3:0]                      mult_q;
    logic [8:0]                      steps_q;
    lsirq_pkg::lsirq_wait_state_t    state_q;

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state_q <= lsirq_pkg::LSIRQ_WAIT_IDLE;
            tick_q  <= 32'h0;
            mult_q  <= 4'h0;
            steps_q <= 9'h0;
        end else begin
            case (state_q)
                lsirq_pkg::LSIRQ_WAIT_IDLE: begin
                    if (start) begin
                        // two's complement count: 0xff gives one step, 0x00 gives 256
                        steps_q <= 9'h100 - {1'b0, wait_count};
                        tick_q  <= 32'h0;
                        mult_q  <= 4'h0;
                        state_q <= lsirq_pkg::LSIRQ_WAIT_RUN;
                    end
                end
                lsirq_pkg::LSIRQ_WAIT_RUN: begin
                    if (tick_q == 32'(STEP_CYCLES - 1)) begin
                        tick_q <= 32'h0;
                        if (long_wait_select
                            && mult_q != 4'(`LSIRQ_LONG_WAIT_FACTOR - 1)) begin
                            mult_q <= mult_q + 4'h1;
                        end else begin
                            mult_q <= 4'h0;
                            if (steps_q == 9'h1) begin
                                state_q <= lsirq_pkg::LSIRQ_WAIT_DONE;
                            end
                            steps_q <= steps_q - 9'h1;
                        end
                    end else begin
                        tick_q <= tick_q + 32'h1;
                    end
                end
                default: begin
                    state_q <= lsirq_pkg::LSIRQ_WAIT_IDLE;
                end
            endcase
        end
    end

    assign busy = (state_q == lsirq_pkg::LSIRQ_WAIT_RUN);
    assign done = (state_q == lsirq_pkg::LSIRQ_WAIT_DONE);
endmodule // lsirq_wait_timer

// File: bench/lsirq_asserts.sv
`timescale 1ns/1ps
module lsirq_asserts #(
    parameter logic [3:0] DIE_REVISION = 4'h1,
    parameter logic [5:0] PART_ID      = 6'h2a,
    parameter logic [1:0] VARIANT_CODE = 2'h1
) (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic       light_interrupt_enable,
    input wire logic       conversion_enable,
    input wire logic       conversion_done,
    input wire logic       saturation_flag,
    input wire logic       wait_start,
    input wire logic [7:0] wait_count,
    input wire logic       wait_busy,
    input wire logic       wait_done,
    input wire logic [1:0] conversion_gain_select,
    input wire logic       long_wait_select,
    input wire logic       threshold_interrupt_flag,
    input wire logic       saturation_irq_pending,
    input wire logic       int_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire clr_wr = reg_wr && reg_addr[7:1] == 7'h73;
    wire conv   = conversion_done && conversion_enable;

    chk_int_cause: assert property ($rose(int_oe) |-> $past((threshold_interrupt_flag
        && light_interrupt_enable) || saturation_irq_pending))
        else $error("int_oe rose without cause");
    chk_int_gated: assert property (!light_interrupt_enable && !saturation_irq_pending
        |=> !int_oe)
        else $error("int_oe high while disabled");
    chk_flag_cause: assert property ($rose(threshold_interrupt_flag) |-> $past(conv))
        else $error("flag rose without conversion");
    chk_flag_clear: assert property (clr_wr && !conv |=> !threshold_interrupt_flag)
        else $error("flag survived clear");
    chk_flag_holds: assert property (threshold_interrupt_flag && !clr_wr |=> threshold_interrupt_flag)
        else $error("flag dropped without clear");
    chk_sat_clear: assert property (clr_wr && !saturation_flag |=> !saturation_irq_pending)
        else $error("saturation survived clear");
    chk_gain_field: assert property (reg_wr && reg_addr == 8'h8f |=> conversion_gain_select == $past(reg_wdata[1:0]))
        else $error("gain not taken");
    chk_long_bit: assert property (reg_wr && reg_addr == 8'h8d |=> long_wait_select == $past(reg_wdata[1]))
        else $error("long wait not taken");
    chk_id_read: assert property (reg_rd && reg_addr == 8'h92 |=> reg_rdata == {PART_ID, VARIANT_CODE})
        else $error("id read wrong");
    chk_rev_read: assert property (reg_rd && reg_addr == 8'h91 |=> reg_rdata == {4'h0, DIE_REVISION})
        else $error("revision read wrong");
    // bounds suit a step of 4 cycles, two steps, long wait
    chk_long_wait: assert property (wait_start && !wait_busy && wait_count == 8'hfe && long_wait_select
        |=> !wait_done [*8] ##[80:95] wait_done)
        else $error("long wait length wrong");
endmodule // lsirq_asserts

bind lsirq_regs lsirq_asserts #(.DIE_REVISION(DIE_REVISION), .PART_ID(PART_ID),
    .VARIANT_CODE(VARIANT_CODE)) chk (.clk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .light_interrupt_enable, .conversion_enable, .conversion_done, .saturation_flag,
    .wait_start, .wait_count, .wait_busy, .wait_done, .conversion_gain_select, .long_wait_select,
    .threshold_interrupt_flag, .saturation_irq_pending, .int_oe);

// File: bench/lsirq_host.sv
`timescale 1ns/1ps
module lsirq_host (
    input  wire logic       clk,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wdata
);
    logic [15:0] exp_q[$];
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = (a == 8'h8c) ? (d & 8'h0f)
                  : (a == 8'h8d) ? ((d & 8'h02) | 8'h40) : d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~reg_wdata;
    endtask
    // expected byte is noted with its address for the read monitor
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        exp_q.push_back({a, e});
        @(negedge clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
    endtask
endmodule // lsirq_host

// File: bench/test_light_sensor_irq_config_regs.sv
`timescale 1ns/1ps
module test_light_sensor_irq_config_regs;
    localparam int         STEP = 4;
    localparam logic [3:0] DIE  = 4'h6;  // arbitrary value
    localparam logic [5:0] PID  = 6'h15; // arbitrary value
    localparam logic [1:0] VAR  = 2'h2;  // arbitrary value
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        reg_wr, reg_rd, rd_seen, wait_busy, wait_done, long_wait_select;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, wait_count;
    logic        light_interrupt_enable, conversion_enable, conversion_done, saturation_flag;
    logic        wait_start, threshold_interrupt_flag, saturation_irq_pending, int_out, int_oe;
    logic [1:0]  conversion_gain_select;
    logic [15:0] clear_channel_result, ent;
    logic [31:0] rnd = 32'ha1a14572;
    int          error_cnt = 0;
    int          n_checks = 0;
    int          n, cyc;
    logic [7:0]  atab [8] = '{8'h84, 8'h85, 8'h86, 8'h87, 8'h8c, 8'h8d, 8'h8f, 8'h90};
    logic [7:0]  mtab [8] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'h0f, 8'h42, 8'h03, 8'h20};

    always #50 clk = ~clk;
    lsirq_host host (.clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
    lsirq_regs #(.DIE_REVISION(DIE), .PART_ID(PID), .VARIANT_CODE(VAR), .STEP_CYCLES(STEP)) dut (
        .clk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
        .light_interrupt_enable, .conversion_enable, .conversion_done, .clear_channel_result,
        .saturation_flag, .wait_start, .wait_count, .wait_busy, .wait_done,
        .conversion_gain_select, .long_wait_select, .threshold_interrupt_flag,
        .saturation_irq_pending, .int_out, .int_oe);

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic summarize;
        if (error_cnt == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic conv(input logic [15:0] v);
        @(negedge clk);
        clear_channel_result = v;
        conversion_done = 1'b1;
        @(negedge clk);
        conversion_done = 1'b0;
        clear_channel_result = ~v;
    endtask
    task automatic out_conv;
        rnd = lfsr(rnd);
        conv(rnd[0] ? 16'h2001 : 16'h0fff);
    endtask
    task automatic settle;
        repeat (2) @(negedge clk);
    endtask

    always @(posedge clk) rd_seen <= reg_rd;
    always @(negedge clk) begin
        if (rd_seen) begin
            ent = host.exp_q.pop_front();
            check($sformatf("reg_%h", ent[15:8]), {8'h00, reg_rdata}, {8'h00, ent[7:0]});
        end
    end
    initial begin
        #3000000;
        error_cnt++;
        summarize;
    end

    initial begin
        {light_interrupt_enable, conversion_enable, conversion_done, saturation_flag} = 4'h0;
        wait_start = 1'b0;
        wait_count = 8'hfe;
        clear_channel_result = 16'h0000;
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        host.rd(8'h8d, 8'h40);
        host.rd(8'h91, {4'h0, DIE});
        host.wr(8'h92, 8'h00);
        host.rd(8'h92, {PID, VAR});
        host.rd(8'ha0, 8'h00);
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            host.wr(atab[i], rnd[7:0]);
            host.rd(atab[i], (rnd[7:0] & mtab[i]) | (i == 5 ? 8'h40 : 8'h00));
            if (i == 5) check("long_wait", 16'(long_wait_select), 16'(rnd[1]));
        end
        for (int g = 0; g < 4; g++) begin
            host.wr(8'h8f, 8'(g));
            check("gain", 16'(conversion_gain_select), 16'(g));
        end
        light_interrupt_enable = 1'b1;
        conversion_enable = 1'b1;
        host.wr(8'h84, 8'h00);
        host.wr(8'h85, 8'h10);
        host.wr(8'h86, 8'h00);
        host.wr(8'h87, 8'h20);
        for (int c = 0; c < 16; c++) begin
            n = (c == 0) ? 1 : (c < 4) ? c : 5 * (c - 3);
            host.wr(8'h8c, 8'(c));
            host.wr(8'he7, 8'h00);
            repeat (n - 1) out_conv;
            if (c > 1) begin
                conv(rnd[1] ? 16'h1000 : 16'h2000);
                repeat (n - 1) out_conv;
            end
            settle;
            check("flag_early", 16'(threshold_interrupt_flag), 16'h0000);
            if (c == 0) conv(16'h1000);
            else out_conv;
            settle;
            check("flag", 16'(threshold_interrupt_flag), 16'h0001);
            check("int_oe", 16'(int_oe), 16'h0001);
        end
        host.wr(8'he6, rnd[7:0]);
        settle;
        check("flag_clr", 16'(threshold_interrupt_flag), 16'h0000);
        check("int_clr", 16'(int_oe), 16'h0000);
        light_interrupt_enable = 1'b0;
        host.wr(8'h8c, 8'h01);
        out_conv;
        settle;
        check("flag_gated", 16'(threshold_interrupt_flag), 16'h0001);
        check("int_gated", 16'(int_oe), 16'h0000);
        host.wr(8'he7, 8'h00);
        conversion_enable = 1'b0;
        out_conv;
        settle;
        check("flag_off", 16'(threshold_interrupt_flag), 16'h0000);
        for (int s = 0; s < 4; s++) begin
            host.wr(8'h90, (s > 0) ? 8'h20 : 8'h00);
            @(negedge clk) saturation_flag = 1'b1;
            @(negedge clk) saturation_flag = 1'b0;
            settle;
            check("sat", 16'(saturation_irq_pending), 16'(s > 0));
            check("sat_int", 16'(int_oe), 16'(s > 0));
            host.wr(8'he4 + 8'(s), 8'h5a);
            settle;
            check("sat_clr", 16'(saturation_irq_pending), 16'(s == 1));
        end
        check("int_out", 16'(int_out), 16'h0000);
        for (int l = 0; l < 2; l++) begin
            host.wr(8'h8d, l ? 8'h42 : 8'h40);
            @(negedge clk) wait_start = 1'b1;
            @(negedge clk) wait_start = 1'b0;
            check("wait_busy", 16'(wait_busy), 16'h0001);
            cyc = 1;
            while (wait_done !== 1'b1 && cyc < 200) begin
                @(negedge clk);
                cyc++;
            end
            n = 2 * STEP * (l ? 12 : 1);
            check("wait_len", 16'(cyc >= n && cyc <= n + 2), 16'h0001);
        end
        summarize;
    end
endmodule // test_light_sensor_irq_config_regs
